// [hw/eap_pins.sv]
// enhanced audio port clock and frame pin logic with flag capture fifo
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps

module eap_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rstn,
	// fill side
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	// drain side
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin
		$error("eap_fifo depth must be a power of two of at least 2");
	end

	assign o_in_ready = (count != DEPTH[AW:0]);
	assign o_out_valid = (count != '0);
	assign o_out_data = mem[rd_ptr];
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;

	always_ff @(posedge i_mclk) begin
		if (push) begin
			mem[wr_ptr] <= i_in_data;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule

module eap_pins #(
	parameter int FIFO_DEPTH = 4,
	parameter int FIFO_WIDTH = 8
) (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rstn,
	// register port
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	// receiver high-frequency clock pin
	input wire logic i_rx_hf_clk,
	output logic o_rx_hf_clk,
	output logic o_rx_hf_clk_oe,
	// transmitter high-frequency clock pin
	input wire logic i_tx_hf_clk,
	output logic o_tx_hf_clk,
	output logic o_tx_hf_clk_oe,
	// receiver frame sync pin
	input wire logic i_rx_fs,
	output logic o_rx_fs,
	output logic o_rx_fs_oe,
	// transmitter frame sync pin
	input wire logic i_tx_fs,
	output logic o_tx_fs,
	output logic o_tx_fs_oe,
	// per-direction timing strobes for the serial logic
	output logic o_rx_tick,
	output logic o_tx_tick,
	output logic o_rx_frame,
	output logic o_tx_frame
);
	localparam int TX = 1;
	localparam int RX = 0;

	if (FIFO_WIDTH < 2 || FIFO_WIDTH > 32) begin
		$error("eap_pins fifo width must lie between 2 and 32");
	end

	localparam int DIV_CNT_W = eap_pkg::DIV_W;
	logic [eap_pkg::CTRL_W-1:0] ctrl;
	logic [eap_pkg::CLK_W-1:0] clk_cfg [2];
	logic [7:0] pcfg;
	logic [3:0] pdat;
	logic in_flag_one;
	logic ovf;
	logic [eap_pkg::NPINS-1:0] pin_in;
	logic [eap_pkg::NPINS-1:0] sync1;
	logic [eap_pkg::NPINS-1:0] sync2;
	logic [eap_pkg::NPINS-1:0] sync3;
	logic [eap_pkg::NPINS-1:0] pin_rise;
	logic [DIV_CNT_W-1:0] div_cnt [2];
	logic [1:0] hf_gen;
	logic [1:0] tick;
	logic [eap_pkg::SLEN_W-1:0] slot_cnt [2];
	logic [eap_pkg::SLOTS_W-1:0] slot_idx [2];
	logic [1:0] slot_end;
	logic [1:0] gen_frame;
	logic [1:0] frame_in;
	logic [1:0] own_frame;
	logic rx_frame_evt;
	logic flag_evt;
	logic port_en;
	logic sync_mode;
	logic flag_role;
	logic bufen_role;
	logic out_flag_pin;
	logic [FIFO_WIDTH-2:0] frame_no;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_pop;
	logic [FIFO_WIDTH-1:0] fifo_out_data;
	logic [eap_pkg::NPINS-1:0] next_pin_out;
	logic [eap_pkg::NPINS-1:0] next_pin_oe;
	logic [eap_pkg::NPINS-1:0] func_out;
	logic [eap_pkg::NPINS-1:0] func_oe;
	logic [31:0] next_rdata;

	assign pin_in = {i_tx_fs, i_rx_fs, i_tx_hf_clk, i_rx_hf_clk};
	assign port_en = ctrl[eap_pkg::CTRL_EN];
	assign sync_mode = ctrl[eap_pkg::CTRL_SYNC];

	// pins are asynchronous to i_mclk; stage three only feeds edge detection
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
		end else begin
			sync1 <= pin_in;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end
	assign pin_rise = sync2 & ~sync3;

	// register writes
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			ctrl <= eap_pkg::CTRL_RST;
			clk_cfg[RX] <= eap_pkg::CLK_RST;
			clk_cfg[TX] <= eap_pkg::CLK_RST;
			pcfg <= eap_pkg::PCFG_RST;
			pdat <= eap_pkg::PDAT_RST;
		end else if (i_wr) begin
			unique case (i_addr)
				eap_pkg::OFS_CTRL: ctrl <= i_wdata[eap_pkg::CTRL_W-1:0];
				eap_pkg::OFS_RXCLK: clk_cfg[RX] <= i_wdata[eap_pkg::CLK_W-1:0];
				eap_pkg::OFS_TXCLK: clk_cfg[TX] <= i_wdata[eap_pkg::CLK_W-1:0];
				eap_pkg::OFS_PCFG: pcfg <= i_wdata[7:0];
				eap_pkg::OFS_PDAT: pdat <= i_wdata[3:0];
				default: ;
			endcase
		end
	end

	// per-direction clocking, high-frequency output and slot/frame timing
	for (genvar d = 0; d < 2; d++) begin : g_dir
		localparam int HF = (d == RX) ? eap_pkg::PIN_RXHF : eap_pkg::PIN_TXHF;
		localparam int FS = (d == RX) ? eap_pkg::PIN_RXFS : eap_pkg::PIN_TXFS;
		logic [DIV_CNT_W-1:0] div_max;
		logic [eap_pkg::SLEN_W-1:0] slen;
		logic [eap_pkg::SLOTS_W-1:0] slots;
		logic fs_is_out;

		assign div_max = clk_cfg[d][eap_pkg::CLK_DIV_LSB +: DIV_CNT_W];
		assign slen = clk_cfg[d][eap_pkg::CLK_SLEN_LSB +: eap_pkg::SLEN_W];
		assign slots = clk_cfg[d][eap_pkg::CLK_SLOTS_LSB +: eap_pkg::SLOTS_W];
		assign fs_is_out = clk_cfg[d][eap_pkg::CLK_FSD];

		// input hf pin replaces the core clock, chosen per direction
		assign tick[d] = (clk_cfg[d][eap_pkg::CLK_SRC] && !clk_cfg[d][eap_pkg::CLK_HFD]) ? pin_rise[HF] : 1'b1;

		// output hf clock: core clock divided by 2*(div+1)
		always_ff @(posedge i_mclk) begin
			if (!i_rstn) begin
				div_cnt[d] <= '0;
				hf_gen[d] <= 1'b0;
			end else if (div_cnt[d] == div_max) begin
				div_cnt[d] <= '0;
				hf_gen[d] <= ~hf_gen[d];
			end else begin
				div_cnt[d] <= div_cnt[d] + 1'b1;
			end
		end

		// an incoming frame edge realigns the slot counters
		assign frame_in[d] = !fs_is_out && pin_rise[FS];
		assign slot_end[d] = tick[d] && (slot_cnt[d] == slen);
		assign gen_frame[d] = slot_end[d] && (slot_idx[d] == slots);
		assign own_frame[d] = fs_is_out ? gen_frame[d] : frame_in[d];

		always_ff @(posedge i_mclk) begin
			if (!i_rstn) begin
				slot_cnt[d] <= '0;
				slot_idx[d] <= '0;
			end else if (frame_in[d] || gen_frame[d]) begin
				slot_cnt[d] <= '0;
				slot_idx[d] <= '0;
			end else if (slot_end[d]) begin
				slot_cnt[d] <= '0;
				slot_idx[d] <= slot_idx[d] + 1'b1;
			end else if (tick[d]) begin
				slot_cnt[d] <= slot_cnt[d] + 1'b1;
			end
		end
	end

	// synchronous mode hands the receiver the transmitter frame
	assign rx_frame_evt = sync_mode ? own_frame[TX] : own_frame[RX];
	assign flag_evt = ctrl[eap_pkg::CTRL_NET] ? slot_end[TX] : own_frame[TX];
	assign flag_role = sync_mode && !ctrl[eap_pkg::CTRL_TX_BUFFER_ENABLE_SELECT];
	assign bufen_role = sync_mode && ctrl[eap_pkg::CTRL_TX_BUFFER_ENABLE_SELECT] && clk_cfg[RX][eap_pkg::CLK_FSD];

	// output flag changes only on the frame or slot boundary
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			out_flag_pin <= 1'b0;
		end else if (flag_evt) begin
			out_flag_pin <= ctrl[eap_pkg::CTRL_OF1];
		end
	end

	// input flag capture, logged to the fifo; a full fifo drops the sample
	assign fifo_in_valid = port_en && flag_role && !clk_cfg[RX][eap_pkg::CLK_FSD] && flag_evt;
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			in_flag_one <= 1'b0;
			frame_no <= '0;
		end else begin
			if (fifo_in_valid) begin
				in_flag_one <= sync2[eap_pkg::PIN_RXFS];
			end
			if (own_frame[TX]) begin
				frame_no <= frame_no + 1'b1;
			end
		end
	end

	// lost flag samples stay flagged until written one; a new loss wins
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			ovf <= 1'b0;
		end else if (fifo_in_valid && !fifo_in_ready) begin
			ovf <= 1'b1;
		end else if (i_wr && i_addr == eap_pkg::OFS_STAT && i_wdata[eap_pkg::STAT_OVF]) begin
			ovf <= 1'b0;
		end
	end

	assign fifo_pop = i_rd && (i_addr == eap_pkg::OFS_FIFO);

	eap_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_mclk(i_mclk),
		.i_rstn(i_rstn),
		.i_in_valid(fifo_in_valid),
		.o_in_ready(fifo_in_ready),
		.i_in_data({frame_no, sync2[eap_pkg::PIN_RXFS]}),
		.o_out_valid(fifo_out_valid),
		.i_out_ready(fifo_pop),
		.o_out_data(fifo_out_data)
	);

	// audio-function pin roles
	always_comb begin
		func_out = '0;
		func_oe = '0;
		func_out[eap_pkg::PIN_RXHF] = hf_gen[RX];
		func_oe[eap_pkg::PIN_RXHF] = clk_cfg[RX][eap_pkg::CLK_HFD];
		func_out[eap_pkg::PIN_TXHF] = hf_gen[TX];
		func_oe[eap_pkg::PIN_TXHF] = clk_cfg[TX][eap_pkg::CLK_HFD];
		func_out[eap_pkg::PIN_TXFS] = (slot_idx[TX] == '0);
		func_oe[eap_pkg::PIN_TXFS] = clk_cfg[TX][eap_pkg::CLK_FSD];
		func_oe[eap_pkg::PIN_RXFS] = clk_cfg[RX][eap_pkg::CLK_FSD];
		if (bufen_role) begin
			func_out[eap_pkg::PIN_RXFS] = ctrl[eap_pkg::CTRL_TXEN];
		end else if (flag_role) begin
			func_out[eap_pkg::PIN_RXFS] = out_flag_pin;
		end else if (sync_mode) begin
			func_oe[eap_pkg::PIN_RXFS] = 1'b0;
		end else begin
			func_out[eap_pkg::PIN_RXFS] = (slot_idx[RX] == '0);
		end
	end

	// general-purpose fallback per pin
	always_comb begin
		next_pin_out = func_out;
		next_pin_oe = func_oe;
		if (!port_en) begin
			for (int p = 0; p < eap_pkg::NPINS; p++) begin
				next_pin_out[p] = pdat[p];
				next_pin_oe[p] = (pcfg[2*p +: 2] == eap_pkg::EAP_PIN_OUT);
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			o_rx_hf_clk <= 1'b0;
			o_tx_hf_clk <= 1'b0;
			o_rx_fs <= 1'b0;
			o_tx_fs <= 1'b0;
			o_rx_hf_clk_oe <= 1'b0;
			o_tx_hf_clk_oe <= 1'b0;
			o_rx_fs_oe <= 1'b0;
			o_tx_fs_oe <= 1'b0;
		end else begin
			o_rx_hf_clk <= next_pin_out[eap_pkg::PIN_RXHF];
			o_tx_hf_clk <= next_pin_out[eap_pkg::PIN_TXHF];
			o_rx_fs <= next_pin_out[eap_pkg::PIN_RXFS];
			o_tx_fs <= next_pin_out[eap_pkg::PIN_TXFS];
			o_rx_hf_clk_oe <= next_pin_oe[eap_pkg::PIN_RXHF];
			o_tx_hf_clk_oe <= next_pin_oe[eap_pkg::PIN_TXHF];
			o_rx_fs_oe <= next_pin_oe[eap_pkg::PIN_RXFS];
			o_tx_fs_oe <= next_pin_oe[eap_pkg::PIN_TXFS];
		end
	end

	// timing strobes for the serial shifters, gated to audio mode
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			o_rx_tick <= 1'b0;
			o_tx_tick <= 1'b0;
			o_rx_frame <= 1'b0;
			o_tx_frame <= 1'b0;
		end else begin
			o_rx_tick <= port_en && (sync_mode ? tick[TX] : tick[RX]);
			o_tx_tick <= port_en && tick[TX];
			o_rx_frame <= port_en && rx_frame_evt;
			o_tx_frame <= port_en && own_frame[TX];
		end
	end

	// read mux; pins disconnected in port mode read as zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		unique case (i_addr)
			eap_pkg::OFS_CTRL: next_rdata[eap_pkg::CTRL_W-1:0] = ctrl;
			eap_pkg::OFS_RXCLK: next_rdata[eap_pkg::CLK_W-1:0] = clk_cfg[RX];
			eap_pkg::OFS_TXCLK: next_rdata[eap_pkg::CLK_W-1:0] = clk_cfg[TX];
			eap_pkg::OFS_STAT: begin
				next_rdata[eap_pkg::STAT_IF1] = in_flag_one;
				next_rdata[eap_pkg::STAT_OVF] = ovf;
				next_rdata[eap_pkg::STAT_EMPTY] = !fifo_out_valid;
				next_rdata[eap_pkg::STAT_FULL] = !fifo_in_ready;
			end
			eap_pkg::OFS_PCFG: next_rdata[7:0] = pcfg;
			eap_pkg::OFS_PDAT: begin
				for (int p = 0; p < eap_pkg::NPINS; p++) begin
					next_rdata[p] = (pcfg[2*p +: 2] == eap_pkg::EAP_PIN_IN) && sync2[p];
				end
			end
			eap_pkg::OFS_FIFO: begin
				next_rdata[FIFO_WIDTH-1:0] = fifo_out_valid ? fifo_out_data : '0;
				next_rdata[31] = fifo_out_valid;
			end
			default: ;
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			o_rdata <= 32'h0000_0000;
		end else if (i_rd) begin
			o_rdata <= next_rdata;
		end else begin
			o_rdata <= 32'h0000_0000;
		end
	end
endmodule

// [hw/eap_pkg.sv]
// shared constants for the enhanced audio port pin block
package eap_pkg;
	// register offsets (byte addresses)
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_RXCLK = 8'h04;
	localparam logic [7:0] OFS_TXCLK = 8'h08;
	localparam logic [7:0] OFS_STAT = 8'h0c;
	localparam logic [7:0] OFS_PCFG = 8'h10;
	localparam logic [7:0] OFS_PDAT = 8'h14;
	localparam logic [7:0] OFS_FIFO = 8'h18;
	// common_control_reg fields
	localparam int CTRL_SYNC = 0;
	localparam int CTRL_TX_BUFFER_ENABLE_SELECT = 1;
	localparam int CTRL_OF1 = 2;
	localparam int CTRL_NET = 3;
	localparam int CTRL_EN = 4;
	localparam int CTRL_TXEN = 5;
	localparam int CTRL_W = 6;
	// rx/tx clock control fields
	localparam int CLK_FSD = 0;
	localparam int CLK_HFD = 1;
	localparam int CLK_SRC = 2;
	localparam int CLK_DIV_LSB = 4;
	localparam int DIV_W = 4;
	localparam int CLK_SLEN_LSB = 8;
	localparam int SLEN_W = 8;
	localparam int CLK_SLOTS_LSB = 16;
	localparam int SLOTS_W = 4;
	localparam int CLK_W = 20;
	// common_status_reg fields
	localparam int STAT_IF1 = 0;
	localparam int STAT_OVF = 1;
	localparam int STAT_EMPTY = 2;
	localparam int STAT_FULL = 3;
	// reset values
	localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
	localparam logic [CLK_W-1:0] CLK_RST = 20'h00000;
	localparam logic [7:0] PCFG_RST = 8'h00;
	localparam logic [3:0] PDAT_RST = 4'h0;
	// pin indices inside the 4-pin vectors
	localparam int PIN_RXHF = 0;
	localparam int PIN_TXHF = 1;
	localparam int PIN_RXFS = 2;
	localparam int PIN_TXFS = 3;
	localparam int NPINS = 4;
	// per-pin general-purpose configuration
	typedef enum logic [1:0] {
		EAP_PIN_OFF = 2'h0,
		EAP_PIN_IN = 2'h1,
		EAP_PIN_OUT = 2'h2
	} eap_pin_cfg_t;
endpackage

// [tb/eap_codec_model.sv]
// codec model: link clock, frame pulses and flag level on the pins
`timescale 1ns/1ps
module eap_codec_model (
	// block side of the pins
	input wire logic [3:0] i_oe,
	input wire logic [3:0] i_drv,
	// scenario controls
	input wire logic i_clk_on,
	input wire logic i_fs_on,
	input wire logic i_flag,
	// resolved pin levels
	output logic [3:0] o_pin
);
	logic hf = 1'b0;
	logic fs = 1'b0;
	logic [1:0] cnt = 2'h0;
	logic [3:0] ext;
	// odd start keeps link edges off the core clock edges
	initial begin
		#137;
		forever begin
			#400 hf = i_clk_on & ~hf;
		end
	end
	always @(posedge hf) begin
		cnt <= cnt + 2'h1;
		fs <= cnt == 2'h3;
	end
	assign ext = {i_fs_on ? fs : i_flag, i_fs_on ? fs : i_flag, hf, hf};
	// the codec level shows wherever the block does not drive
	assign o_pin = (i_oe & i_drv) | (~i_oe & ext);
endmodule

// [tb/eap_pins_asserts.sv]
// checker on the audio port pin block ports
`timescale 1ns/1ps
module eap_pins_asserts (
	// clock, reset, register writes
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	// pins and strobes
	input wire logic i_rx_hf_clk,
	input wire logic o_rx_hf_clk,
	input wire logic o_rx_hf_clk_oe,
	input wire logic o_tx_hf_clk,
	input wire logic o_tx_hf_clk_oe,
	input wire logic o_rx_fs,
	input wire logic o_rx_fs_oe,
	input wire logic o_tx_fs,
	input wire logic o_tx_fs_oe,
	input wire logic o_rx_tick,
	input wire logic o_tx_tick
);
	logic [5:0] ctrl;
	logic [7:0] rxc;
	logic [7:0] txc;
	logic [7:0] pcfg;
	logic [3:0] pdat;
	logic [1:0] wr_hist;
	logic [3:0] oe;
	logic [3:0] drv;
	logic [3:0] want;
	logic en;
	logic quiet;
	assign oe = {o_tx_fs_oe, o_rx_fs_oe, o_tx_hf_clk_oe, o_rx_hf_clk_oe};
	assign drv = {o_tx_fs, o_rx_fs, o_tx_hf_clk, o_rx_hf_clk};
	assign want = {pcfg[7:6] == 2'h2, pcfg[5:4] == 2'h2, pcfg[3:2] == 2'h2, pcfg[1:0] == 2'h2};
	assign en = ctrl[4];
	// pins lag a write by two edges, so judge only once settled
	assign quiet = wr_hist == 2'h0;
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			ctrl <= 6'h00;
			rxc <= 8'h00;
			txc <= 8'h00;
			pcfg <= 8'h00;
			pdat <= 4'h0;
		end else if (i_wr) begin
			case (i_addr)
				eap_pkg::OFS_CTRL: ctrl <= i_wdata[5:0];
				eap_pkg::OFS_RXCLK: rxc <= i_wdata[7:0];
				eap_pkg::OFS_TXCLK: txc <= i_wdata[7:0];
				eap_pkg::OFS_PCFG: pcfg <= i_wdata[7:0];
				eap_pkg::OFS_PDAT: pdat <= i_wdata[3:0];
				default: ;
			endcase
		end
	end
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			wr_hist <= 2'h0;
		end else begin
			wr_hist <= {wr_hist[0], i_wr};
		end
	end
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);
	rst_quiet_a: assert property ($rose(i_rstn) |-> oe == 4'h0 && drv == 4'h0 && !o_rx_tick)
		else $error("pins active after reset");
	port_oe_a: assert property (!en && quiet |-> oe == want)
		else $error("port pin enable wrong");
	port_drive_a: assert property (!en && quiet |-> (drv & oe) == (pdat & oe))
		else $error("port pin value wrong");
	hf_dir_a: assert property (en && quiet |-> o_rx_hf_clk_oe == rxc[1] && o_tx_hf_clk_oe == txc[1])
		else $error("hf pin direction wrong");
	hf_toggle_a: assert property (en && quiet && rxc[1] && rxc[7:4] == 4'h0 ##1 quiet |-> $changed(o_rx_hf_clk))
		else $error("hf clock not toggling");
	tx_fs_dir_a: assert property (en && quiet |-> o_tx_fs_oe == txc[0])
		else $error("tx frame pin direction wrong");
	rx_fs_dir_a: assert property (en && quiet && !(ctrl[0] && ctrl[1]) |-> o_rx_fs_oe == rxc[0])
		else $error("rx frame pin direction wrong");
	buf_enable_a: assert property (en && quiet && ctrl[0] && ctrl[1] && rxc[0] |-> o_rx_fs_oe && o_rx_fs == ctrl[5])
		else $error("buffer enable not driven");
	core_tick_a: assert property (en && quiet && !(txc[2] && !txc[1]) |-> o_tx_tick)
		else $error("tx core tick missing");
	hf_tick_a: assert property (en && quiet && !ctrl[0] && rxc[2] && !rxc[1] && $rose(i_rx_hf_clk) |-> ##[1:6] o_rx_tick)
		else $error("rx hf tick missing");
endmodule
bind eap_pins eap_pins_asserts u_chk (.i_mclk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rx_hf_clk, .o_rx_hf_clk,
	.o_rx_hf_clk_oe, .o_tx_hf_clk, .o_tx_hf_clk_oe, .o_rx_fs, .o_rx_fs_oe, .o_tx_fs, .o_tx_fs_oe, .o_rx_tick, .o_tx_tick);

// [tb/eap_pins_bench.sv]
// self-checking bench for the audio port pin block
`timescale 1ns/1ps
module eap_pins_bench;
	logic i_mclk = 1'b0;
	logic i_rstn = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [31:0] o_rdata;
	logic clk_on = 1'b0;
	logic fs_on = 1'b0;
	logic flag = 1'b0;
	logic [3:0] pin;
	logic [3:0] oe;
	logic [3:0] drv;
	logic [3:0] tk;
	logic [31:0] d;
	int cnt [8];
	int bad_count = 0;
	int samples_checked = 0;

	eap_pins DUT (.i_mclk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
		.i_rx_hf_clk(pin[0]), .o_rx_hf_clk(drv[0]), .o_rx_hf_clk_oe(oe[0]),
		.i_tx_hf_clk(pin[1]), .o_tx_hf_clk(drv[1]), .o_tx_hf_clk_oe(oe[1]),
		.i_rx_fs(pin[2]), .o_rx_fs(drv[2]), .o_rx_fs_oe(oe[2]),
		.i_tx_fs(pin[3]), .o_tx_fs(drv[3]), .o_tx_fs_oe(oe[3]),
		.o_rx_tick(tk[0]), .o_tx_tick(tk[1]), .o_rx_frame(tk[2]), .o_tx_frame(tk[3]));
	eap_codec_model codec (.i_oe(oe), .i_drv(drv), .i_clk_on(clk_on), .i_fs_on(fs_on), .i_flag(flag), .o_pin(pin));

	initial begin
		forever #50 i_mclk = ~i_mclk;
	end

	task conclude;
		$display("checks %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge i_mclk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask

	task rd(input logic [7:0] a);
		@(posedge i_mclk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask

	task settle;
		repeat (4) @(posedge i_mclk);
		#1;
	endtask

	// counts strobes, hf pin changes and rx/tx frame disagreement
	task run(input int n);
		logic rh;
		logic th;
		cnt = '{default: 0};
		rh = drv[0];
		th = drv[1];
		repeat (n) begin
			@(posedge i_mclk);
			#1;
			for (int k = 0; k < 4; k++) cnt[k] += (tk[k] === 1'b1);
			cnt[4] += (drv[0] !== rh);
			cnt[5] += (drv[1] !== th);
			cnt[6] += (tk[2] !== tk[3]);
			cnt[7] += (drv[3] === 1'b1);
			rh = drv[0];
			th = drv[1];
		end
	endtask

	task t_reset;
		chk({28'h0, oe | drv}, 32'h0);
		rd(eap_pkg::OFS_PCFG);
		chk(d, 32'h0);
	endtask

	task t_port;
		flag <= 1'b1;
		wr(eap_pkg::OFS_PDAT, 32'h5);
		wr(eap_pkg::OFS_PCFG, 32'h62);
		settle;
		chk({28'h0, oe}, 32'h5);
		chk({28'h0, drv & oe}, 32'h5);
		rd(eap_pkg::OFS_PDAT);
		chk(d, 32'h8);
		wr(eap_pkg::OFS_PCFG, 32'h0);
		rd(eap_pkg::OFS_PDAT);
		chk(d, 32'h0);
		rd(8'h1c);
		chk(d, 32'h0);
		flag <= 1'b0;
	endtask

	// one hf pin drives a clock out while the other clocks its direction
	task t_hf;
		clk_on <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			wr(eap_pkg::OFS_RXCLK, i ? 32'h4 : 32'h2);
			wr(eap_pkg::OFS_TXCLK, i ? 32'h2 : 32'h4);
			wr(eap_pkg::OFS_CTRL, 32'h10);
			settle;
			chk({28'h0, oe}, i ? 32'h2 : 32'h1);
			run(160);
			chk(32'(cnt[4 + i]), 32'ha0);
			chk(32'(cnt[1 - i]), 32'h14);
			chk(32'(cnt[i]), 32'ha0);
		end
		wr(eap_pkg::OFS_CTRL, 32'h0);
		clk_on <= 1'b0;
	endtask

	task t_flag;
		logic [6:0] f0;
		logic [6:0] df;
		flag <= 1'b1;
		wr(eap_pkg::OFS_RXCLK, 32'h0);
		wr(eap_pkg::OFS_TXCLK, 32'h10001);
		// normal mode logs once a frame, network mode once a slot
		for (int m = 0; m < 2; m++) begin
			wr(eap_pkg::OFS_CTRL, m ? 32'h19 : 32'h11);
			run(20);
			chk({28'h0, oe}, 32'h8);
			rd(eap_pkg::OFS_STAT);
			chk(d, 32'hb);
			wr(eap_pkg::OFS_CTRL, 32'h0);
			// fifo held full while nobody read it; now drain it
			for (int i = 0; i < 5; i++) begin
				rd(eap_pkg::OFS_FIFO);
				chk(d & 32'h80000001, i < 4 ? 32'h80000001 : 32'h0);
				if (i == 0) begin
					f0 = d[7:1];
				end
				if (i == 2) begin
					df = d[7:1] - f0;
					chk({25'h0, df}, m ? 32'h1 : 32'h2);
				end
			end
			wr(eap_pkg::OFS_STAT, 32'h2);
			rd(eap_pkg::OFS_STAT);
			chk(d & 32'he, 32'h4);
		end
		wr(eap_pkg::OFS_RXCLK, 32'h1);
		for (int i = 0; i < 4; i++) begin
			wr(eap_pkg::OFS_CTRL, i[1] ? (i[0] ? 32'h13 : 32'h33) : (i[0] ? 32'h11 : 32'h15));
			settle;
			chk({30'h0, oe[2], drv[2]}, i[0] ? 32'h2 : 32'h3);
		end
		// buffer-enable role with the frame direction in leaves the pin free
		wr(eap_pkg::OFS_RXCLK, 32'h0);
		settle;
		chk({31'h0, oe[2]}, 32'h0);
		wr(eap_pkg::OFS_CTRL, 32'h0);
		flag <= 1'b0;
	endtask

	// async: rx follows its own pin; sync: rx follows tx frames
	task t_frame;
		fs_on <= 1'b1;
		clk_on <= 1'b1;
		wr(eap_pkg::OFS_RXCLK, 32'h0);
		wr(eap_pkg::OFS_TXCLK, 32'h10001);
		for (int i = 0; i < 2; i++) begin
			wr(eap_pkg::OFS_CTRL, i ? 32'h11 : 32'h10);
			settle;
			chk({28'h0, oe}, 32'h8);
			run(640);
			chk(32'(cnt[2]), i ? 32'h140 : 32'h14);
			chk(32'(cnt[3]), 32'h140);
			chk(32'(cnt[6]), i ? 32'h0 : 32'h12c);
			chk(32'(cnt[7]), 32'h140);
		end
	endtask

	initial begin
		repeat (6) @(posedge i_mclk);
		i_rstn <= 1'b1;
		t_reset;
		t_port;
		t_hf;
		t_flag;
		t_frame;
		conclude;
	end

	initial begin
		#1000000;
		bad_count++;
		conclude;
	end
endmodule
